// file: ast_tx_defs.svh
// Register offsets, field positions, reset values and timing counts
// for the asynchronous serial transmitter.
// Assumes a 40 MHz system clock and a 32-bit register bus.
`ifndef AST_TX_DEFS_SVH
`define AST_TX_DEFS_SVH

// Register byte offsets
`define AST_OFF_CTRL        8'h00
`define AST_OFF_DATA        8'h04
`define AST_OFF_STATUS      8'h08

// Control register field positions
`define AST_CTRL_TRANSMIT_ENABLE_BIT_BIT   0
`define AST_CTRL_SYNC_BIT   1
`define AST_CTRL_SERIAL_PORT_ENABLE_BIT_BIT   2
`define AST_CTRL_NINE_BIT   3
`define AST_CTRL_INV_BIT    4
`define AST_CTRL_MASK_BIT   5
`define AST_CTRL_W          6

// Status register field positions
`define AST_STAT_EMPTY_BIT  0
`define AST_STAT_TSR_BIT    1
`define AST_STAT_FULL_BIT   2

// Reset values
`define AST_CTRL_RST        6'h00
`define AST_DATA_RST        9'h000
`define AST_RDATA_RST       32'h0000_0000

// Bus responses
`define AST_RESP_OKAY       2'b00
`define AST_RESP_SLVERR     2'b10

// Timing: clock period, instruction cycle and the flag lag after a write
`define AST_CLK_NS          25
`define AST_TCY_NS          100
`define AST_TCY_CLKS        ((`AST_TCY_NS + `AST_CLK_NS - 1) / `AST_CLK_NS)
`define AST_FLAG_LAG_CLKS   (2 * `AST_TCY_CLKS)

// Baud ticks per bit and stop bits per frame
`define AST_OVS             16
`define AST_STOP_BITS       1

`endif

// file: ast_tx_pkg.sv
// Types shared by the asynchronous serial transmitter.
// Assumes ast_tx_defs.svh supplies the field widths.
`include "ast_tx_defs.svh"

package ast_tx_pkg;

  // Software control bits of the serial port unit
  typedef struct packed {
    logic irq_mask;     // Transmit interrupt mask
    logic pol_inv;      // Transmit polarity invert
    logic nine_bit;     // Nine data bits per character
    logic port_en;      // Serial port enable
    logic sync_sel;     // Clocked mode select
    logic tx_en;        // Transmit enable
  } ast_ctrl_t;

  // Transmit shift register sequencer
  typedef enum logic [1:0] {
    AST_IDLE,
    AST_START,
    AST_DATA,
    AST_STOP
  } ast_state_t;

endpackage

// file: ast_tx.sv
// Asynchronous serial transmitter: one-deep transmit buffer feeding
// a shift register, with control and status over AXI4-Lite.
// Assumes a shared baud generator giving a one-cycle tick, OVS ticks
// per bit, and a single 40 MHz clock with asynchronous active-low reset.
//
// Functional notes
// - Line idles at mark when not shifting
// - Start space, 8/9 data, stop marks
// - Data and stop bits last exactly one baud period; start bit up to a tick short
// - Bit period from shared 8/16-bit divider
// - Data bits leave least significant first
// - Shares format and baud with receiver
// - No hardware parity; software supplies ninth
// - Shift register loads only from buffer
// - Active only when enabled, async, port on
// - Port enable turns serial pin to output
// - Empty flag sets when transmitter active
// - Buffer write starts; idle shifter loads at once
// - Queued character loads within one instruction cycle
// - Start bit begins right after load
// - Polarity bit inverts idle and data, async only
// - Flag clear when busy and queued, or when inactive
// - Flag updates two instruction cycles after write
// - Flag is read-only to software
// - Mask gates interrupt only, not flag
`timescale 1ns/100ps
`default_nettype none
`include "ast_tx_defs.svh"

module ast_tx
  import ast_tx_pkg::*;
#(
  parameter int ADDR_W    = 8,
  parameter int OVS       = `AST_OVS,
  parameter int STOP_BITS = `AST_STOP_BITS
)
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_arst_n,
  // Shared baud generator tick
  input  wire logic              i_baud_tick,
  // Serial pin
  output logic                   o_serial_out,
  output logic                   o_serial_oe_n,
  // Transmit interrupt request
  output logic                   o_tx_irq,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);

  // Refuse settings the counters cannot serve
  if (ADDR_W < 8 || OVS < 1 || OVS > 256 || STOP_BITS < 1
      || STOP_BITS > 8)
  begin : g_bad_param
    $error("ast_tx: unsupported parameter value");
  end

  localparam int OVS_W = (OVS > 1) ? $clog2(OVS) : 1;
  localparam int LAG_W = $clog2(`AST_FLAG_LAG_CLKS + 1);
  localparam logic [OVS_W-1:0] OVS_LAST = OVS_W'(OVS - 1);
  localparam logic [3:0] STOP_LAST = 4'(STOP_BITS - 1);
  localparam logic [LAG_W-1:0] LAG_LOAD = LAG_W'(`AST_FLAG_LAG_CLKS - 1);

  // Word-aligned address match against a byte offset
  function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                   input logic [7:0]        off);
    addr_is = ({a[ADDR_W-1:2], 2'b00} == ADDR_W'(off));
  endfunction

  // Registers
  ast_ctrl_t         ctrl_q;       // Software control bits
  logic [8:0]        buf_q;        // Transmit buffer
  logic              buf_full_q;   // Character waiting in buffer
  logic [8:0]        shift_q;      // Transmit shift register
  ast_state_t        state_q;      // Sequencer state
  logic [3:0]        bit_cnt_q;    // Data or stop bit index
  logic [OVS_W-1:0]  ovs_cnt_q;    // Ticks within current bit
  logic              line_q;       // Line level before polarity
  logic              pin_q;        // Pin level after polarity
  logic              flag_q;       // Transmit buffer empty flag
  logic [LAG_W-1:0]  lag_q;        // Cycles the flag stays stale
  logic              irq_q;        // Masked interrupt request
  logic              bvalid_q;     // Write response pending
  logic [1:0]        bresp_q;      // Write response code
  logic              rvalid_q;     // Read response pending
  logic [31:0]       rdata_q;      // Read data
  logic [1:0]        rresp_q;      // Read response code

  // Decoding and control wires
  logic        tx_active;    // Asynchronous transmit running
  logic        wr_take;      // Write address and data taken
  logic        rd_take;      // Read address taken
  logic        wr_ctrl;      // Control register write
  logic        wr_data;      // Buffer write
  logic        wr_status;    // Status write, ignored
  logic        wr_hit;       // Write hits a mapped register
  logic        rd_ctrl;      // Control register read
  logic        rd_data;      // Buffer address read
  logic        rd_status;    // Status register read
  logic        rd_hit;       // Read hits a mapped register
  logic        load;         // Buffer to shift register move
  logic        bit_done;     // Current bit period ends
  logic        last_data;    // Final data bit being sent
  logic        flag_live;    // Flag value without write lag
  logic        inv_on;       // Polarity inversion in force
  logic [3:0]  data_last;    // Index of final data bit
  logic [31:0] status_word;  // Status register image
  logic [31:0] ctrl_word;    // Control register image

  // Transmitter runs only when enabled, asynchronous and port on
  assign tx_active = ctrl_q.tx_en & ~ctrl_q.sync_sel & ctrl_q.port_en;

  // Bus handshakes: write channels taken together, one at a time
  assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_wready  = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign s_axi_arready = ~rvalid_q;
  assign wr_take       = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  assign rd_take       = s_axi_arvalid & ~rvalid_q;

  // Address decode
  assign wr_ctrl   = wr_take & addr_is(s_axi_awaddr, `AST_OFF_CTRL)
                     & s_axi_wstrb[0];
  assign wr_data   = wr_take & addr_is(s_axi_awaddr, `AST_OFF_DATA)
                     & s_axi_wstrb[0] & tx_active;
  assign wr_status = addr_is(s_axi_awaddr, `AST_OFF_STATUS);
  assign wr_hit    = addr_is(s_axi_awaddr, `AST_OFF_CTRL)
                     | addr_is(s_axi_awaddr, `AST_OFF_DATA) | wr_status;
  assign rd_ctrl   = addr_is(s_axi_araddr, `AST_OFF_CTRL);
  assign rd_data   = addr_is(s_axi_araddr, `AST_OFF_DATA);
  assign rd_status = addr_is(s_axi_araddr, `AST_OFF_STATUS);
  assign rd_hit    = rd_ctrl | rd_data | rd_status;

  // Register images; buffer and shift register read as zero
  assign ctrl_word   = {26'h000_0000, ctrl_q};
  assign status_word = {29'h0000_0000, buf_full_q,
                        (state_q == AST_IDLE), flag_q};

  // Sequencer wires
  assign load      = tx_active & buf_full_q & (state_q == AST_IDLE);
  assign bit_done  = i_baud_tick & (ovs_cnt_q == OVS_LAST);
  assign data_last = ctrl_q.nine_bit ? 4'd8 : 4'd7;
  assign last_data = (bit_cnt_q == data_last);
  assign flag_live = tx_active & ~buf_full_q;
  assign inv_on    = ctrl_q.pol_inv & ~ctrl_q.sync_sel;

  // Outputs
  assign o_serial_out  = pin_q;
  assign o_serial_oe_n = ~ctrl_q.port_en;
  assign o_tx_irq      = irq_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Control register, written by software
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ctrl_q <= ast_ctrl_t'(`AST_CTRL_RST);
    else if (wr_ctrl)
      ctrl_q <= ast_ctrl_t'(s_axi_wdata[`AST_CTRL_W-1:0]);
  end

  // Write response; status writes change nothing
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      bvalid_q <= 1'b0;
      bresp_q  <= `AST_RESP_OKAY;
    end
    else if (wr_take)
    begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  // Read response, data from the register images
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= `AST_RDATA_RST;
      rresp_q  <= `AST_RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q  <= rd_hit ? `AST_RESP_OKAY : `AST_RESP_SLVERR;
      // Shift register is never visible; buffer reads as zero
      if (rd_ctrl)
        rdata_q <= ctrl_word;
      else if (rd_status)
        rdata_q <= status_word;
      else
        rdata_q <= `AST_RDATA_RST;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  // Transmit buffer; a new write wins over a same-cycle move out
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      buf_q      <= `AST_DATA_RST;
      buf_full_q <= 1'b0;
    end
    else if (!tx_active)
      buf_full_q <= 1'b0;
    else if (wr_data)
    begin
      // Ninth bit carries software parity when enabled
      buf_q      <= s_axi_wdata[8:0];
      buf_full_q <= 1'b1;
    end
    else if (load)
      buf_full_q <= 1'b0;
  end

  // Tick counter inside each bit; restarted on every load
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      ovs_cnt_q <= '0;
    else if (!tx_active || load)
      ovs_cnt_q <= '0;
    else if (i_baud_tick && state_q != AST_IDLE)
      ovs_cnt_q <= bit_done ? '0 : ovs_cnt_q + 1'b1;
  end

  // Frame sequencer: start, data bits, stop bits
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_q   <= AST_IDLE;
      shift_q   <= `AST_DATA_RST;
      bit_cnt_q <= 4'd0;
      line_q    <= 1'b1;
    end
    else if (!tx_active)
    begin
      // Disable aborts the frame and returns the line to mark
      state_q <= AST_IDLE;
      line_q  <= 1'b1;
    end
    else
    begin
      unique case (state_q)
        AST_IDLE:
          if (load)
          begin
            // Shift register fed only from the buffer
            shift_q   <= buf_q;
            bit_cnt_q <= 4'd0;
            line_q    <= 1'b0;
            state_q   <= AST_START;
          end
          else
            line_q <= 1'b1;
        AST_START:
          if (bit_done)
          begin
            // Least significant bit goes first
            line_q  <= shift_q[0];
            shift_q <= {1'b0, shift_q[8:1]};
            state_q <= AST_DATA;
          end
        AST_DATA:
          if (bit_done)
          begin
            if (last_data)
            begin
              line_q    <= 1'b1;
              bit_cnt_q <= 4'd0;
              state_q   <= AST_STOP;
            end
            else
            begin
              line_q    <= shift_q[0];
              shift_q   <= {1'b0, shift_q[8:1]};
              bit_cnt_q <= bit_cnt_q + 4'd1;
            end
          end
        AST_STOP:
          if (bit_done)
          begin
            if (bit_cnt_q == STOP_LAST)
              state_q <= AST_IDLE;
            else
              bit_cnt_q <= bit_cnt_q + 4'd1;
          end
      endcase
    end
  end

  // Pin level with optional inversion of idle and data
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      pin_q <= 1'b1;
    else
      pin_q <= line_q ^ inv_on;
  end

  // Empty flag: stale for two instruction cycles after a write
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      flag_q <= 1'b0;
      lag_q  <= '0;
    end
    else if (wr_data)
      lag_q <= LAG_LOAD;
    else if (lag_q != '0)
      lag_q <= lag_q - 1'b1;
    else
      flag_q <= flag_live;
  end

  // Interrupt request, gated by the mask only
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
      irq_q <= 1'b0;
    else
      irq_q <= flag_q & ctrl_q.irq_mask;
  end

endmodule
`default_nettype wire

// file: ast_tx_assertions.sv
// Port checker for the asynchronous serial transmitter.
// Assumes it is bound into ast_tx and keeps a shadow of the control bits.
`timescale 1ns/100ps
`default_nettype none
`include "ast_tx_defs.svh"
module ast_tx_assertions
  import ast_tx_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int OVS    = 16
)
(
  input wire logic              i_clk_sys,
  input wire logic              i_arst_n,
  input wire logic              i_baud_tick,
  input wire logic              o_serial_out,
  input wire logic              o_serial_oe_n,
  input wire logic              o_tx_irq,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_bvalid,
  input wire logic [1:0]        s_axi_bresp
);
  localparam int QUIET = 24 * OVS;  // Ticks that cover two whole frames
  ast_ctrl_t   ctl_q;  // Shadow of the control bits
  logic [11:0] tk_q;   // Ticks since the last accepted character
  logic        wr;     // Write taken at this edge
  logic [7:0]  wa;     // Low byte of the write address
  logic        act;    // Transmitter active
  logic        dwr;    // Accepted character write
  logic        ok;     // Write address is mapped
  logic        idle;   // Idle level after polarity
  assign wr = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
  assign wa = s_axi_awaddr[7:0];
  assign act = ctl_q.tx_en & ~ctl_q.sync_sel & ctl_q.port_en;
  assign dwr = wr & act & (wa == `AST_OFF_DATA) & s_axi_wstrb[0];
  assign ok = wa == `AST_OFF_CTRL || wa == `AST_OFF_DATA
           || wa == `AST_OFF_STATUS;
  assign idle = ~(ctl_q.pol_inv & ~ctl_q.sync_sel);
  // Control shadow follows byte-enabled control writes
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
    if (!i_arst_n)
      ctl_q <= '0;
    else if (wr && wa == `AST_OFF_CTRL && s_axi_wstrb[0])
      ctl_q <= ast_ctrl_t'(s_axi_wdata[5:0]);
  // Saturating tick count since the last character
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
    if (!i_arst_n)
      tk_q <= '1;
    else if (dwr)
      tk_q <= '0;
    else if (i_baud_tick && tk_q != '1)
      tk_q <= tk_q + 12'h001;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  oe_follow_a: assert property ($stable(ctl_q)[*3] |->
    o_serial_oe_n == !ctl_q.port_en) else $error("pin enable wrong");
  idle_mark_a: assert property ($stable(ctl_q)[*3] &&
    (!act || tk_q >= QUIET) |-> o_serial_out == idle)
    else $error("line not at idle level");
  start_lat_a: assert property (dwr && tk_q >= QUIET |->
    ##3 o_serial_out == !idle) else $error("start bit late or wrong");
  irq_gate_a: assert property ((!ctl_q.irq_mask)[*2] |-> !o_tx_irq)
    else $error("request raised while masked");
  irq_set_a: assert property ($rose(act) && ctl_q.irq_mask |->
    ##[1:3] o_tx_irq) else $error("flag did not set on enable");
  flag_lag_a: assert property (dwr && o_tx_irq && ctl_q.irq_mask |=>
    o_tx_irq[*7]) else $error("flag changed too early");
  flag_clr_a: assert property (dwr && ctl_q.irq_mask &&
    tk_q < 7 * OVS |-> ##[8:11] !o_tx_irq) else $error("flag not cleared");
  resp_ok_a: assert property (wr && ok |=> s_axi_bvalid &&
    s_axi_bresp == `AST_RESP_OKAY) else $error("mapped write refused");
  resp_err_a: assert property (wr && !ok |=> s_axi_bvalid &&
    s_axi_bresp == `AST_RESP_SLVERR) else $error("unmapped write accepted");
  cover property (dwr ##3 o_serial_out == !idle);
  cover property ($rose(o_tx_irq));
  cover property (wr && !ok);
endmodule
`default_nettype wire

// file: ast_tx_rx_model.sv
// Remote asynchronous receiver watching the transmitter's line.
// Assumes OVS baud ticks per bit and one character at a time.
`timescale 1ns/100ps
`default_nettype none
module ast_tx_rx_model
  import ast_tx_pkg::*;
#(
  parameter int OVS = 16
)
(
  input  wire logic  i_clk_sys,
  input  wire logic  i_baud_tick,
  input  wire logic  i_line,
  input  wire logic  i_inv,
  input  wire logic  i_nine,
  output logic [8:0] o_data,
  output logic       o_valid,
  output logic       o_stop_ok
);
  logic lvl;  // Line level with polarity removed
  int   nb;   // Data bits per character
  assign lvl = i_line ^ i_inv;
  // Mark to space edge, mid-bit samples, stop check
  always
  begin
    o_valid <= 1'b0;
    @(posedge i_clk_sys iff lvl);
    @(posedge i_clk_sys iff !lvl);
    repeat (OVS / 2) @(posedge i_clk_sys iff i_baud_tick);
    // Short space pulses are glitches, not start bits
    if (!lvl)
    begin
      nb = i_nine ? 9 : 8;
      o_data <= '0;
      for (int i = 0; i < nb; i++)
      begin
        repeat (OVS) @(posedge i_clk_sys iff i_baud_tick);
        o_data[i] <= lvl;
      end
      repeat (OVS) @(posedge i_clk_sys iff i_baud_tick);
      o_stop_ok <= lvl;
      o_valid <= 1'b1;
      @(posedge i_clk_sys);
    end
  end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the asynchronous serial transmitter.
// Assumes the checker and receiver model are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ast_tx_defs.svh"
`define CHK(nm, e, g) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end \
  end
module testbench
  import ast_tx_pkg::*;
;
  localparam logic [7:0] CT = `AST_OFF_CTRL;
  localparam logic [7:0] DA = `AST_OFF_DATA;
  localparam logic [7:0] ST = `AST_OFF_STATUS;
  localparam logic [1:0] OK = `AST_RESP_OKAY;
  localparam logic [1:0] ER = `AST_RESP_SLVERR;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick = 1'b0;
  logic [1:0]  tdiv = 2'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        ser, oe_n, irq, rx_valid, rx_stop;
  logic        inv = 1'b0, nine = 1'b0;
  logic [8:0]  rx_data, ex;
  logic [8:0]  exp_q[$];
  int          fail_count = 0, tests_run = 0, seed = 35;
  always #12.5 clk = ~clk;
  // Baud tick every fourth clock
  always @(posedge clk)
  begin
    tdiv <= tdiv + 2'h1;
    tick <= tdiv == 2'h3;
  end
  ast_tx ast_tx_inst (.i_clk_sys(clk), .i_arst_n(rst_n), .i_baud_tick(tick),
    .o_serial_out(ser), .o_serial_oe_n(oe_n), .o_tx_irq(irq),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp));
  ast_tx_rx_model ast_tx_rx_model_inst (.i_clk_sys(clk), .i_baud_tick(tick),
    .i_line(ser), .i_inv(inv), .i_nine(nine), .o_data(rx_data),
    .o_valid(rx_valid), .o_stop_ok(rx_stop));
  // Bus write, response code checked
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (!(awready && wready));
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do @(posedge clk); while (!bvalid);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask
  // Bus read, data and response checked
  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    rready <= 1'b0;
    `CHK("read", {er, e}, {rresp, rdata})
  endtask
  // Note the expected character, then write it
  task automatic send(input logic [8:0] c);
    exp_q.push_back(nine ? c : {1'b0, c[7:0]});
    wr(DA, {23'h0, c}, OK);
  endtask
  // Wait until the receiver has taken every note
  task automatic drain;
    for (int i = 0; i < 3000 && exp_q.size() != 0; i++) @(posedge clk);
    repeat (40) @(posedge clk);
    `CHK("queue", 0, exp_q.size())
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Compare each received character with the oldest note
  always @(posedge clk)
    if (rx_valid === 1'b1)
    begin
      ex = exp_q.size() != 0 ? exp_q.pop_front() : ~rx_data;
      `CHK("rx data", ex, rx_data)
      `CHK("rx stop", 1'b1, rx_stop)
    end
  // Main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    `CHK("pin", 1'b1, ser)
    `CHK("oe", 1'b1, oe_n)
    rd(CT, 32'h0, OK);
    rd(ST, 32'h2, OK);
    wr(DA, 32'h55, OK);
    repeat (20) @(posedge clk);
    rd(ST, 32'h2, OK);
    `CHK("pin", 1'b1, ser)
    wr(CT, 32'h25, OK);
    rd(ST, 32'h3, OK);
    `CHK("irq", 1'b1, irq)
    `CHK("oe", 1'b0, oe_n)
    $display("test enable done");
    send(9'($random(seed)));
    send(9'($random(seed)));
    rd(ST, 32'h5, OK);
    repeat (10) @(posedge clk);
    rd(ST, 32'h4, OK);
    `CHK("irq", 1'b0, irq)
    drain;
    rd(ST, 32'h3, OK);
    $display("test back to back done");
    // Nine-bit characters, plain then inverted line
    for (int m = 0; m < 2; m++)
    begin
      nine <= 1'b1;
      inv <= m[0];
      wr(CT, 32'h2D | (m << 4), OK);
      repeat (4) @(posedge clk);
      `CHK("idle", ~m[0], ser)
      repeat (2) send(9'($random(seed)));
      drain;
    end
    $display("test nine bit done");
    wr(ST, 32'h0, OK);
    rd(ST, 32'h3, OK);
    rd(DA, 32'h0, OK);
    wr(8'h0C, 32'h1, ER);
    rd(8'h0C, 32'h0, ER);
    wr(CT, 32'h1D, OK);
    rd(ST, 32'h3, OK);
    `CHK("irq", 1'b0, irq)
    wr(DA, 32'h0, OK);
    // Inversion is dropped with the abort, so the receiver follows
    inv <= 1'b0;
    wr(CT, 32'h04, OK);
    repeat (4) @(posedge clk);
    `CHK("pin", 1'b1, ser)
    `CHK("oe", 1'b0, oe_n)
    rd(ST, 32'h2, OK);
    $display("test access and abort done");
    end_of_test;
  end
  // Watchdog well beyond the expected 4300 or so cycles
  initial
  begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test;
  end
endmodule
bind ast_tx ast_tx_assertions #(.ADDR_W(ADDR_W), .OVS(OVS))
  ast_tx_assertions_inst (.i_clk_sys, .i_arst_n, .i_baud_tick,
  .o_serial_out, .o_serial_oe_n, .o_tx_irq, .s_axi_awvalid,
  .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
  .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bresp);
`default_nettype wire
